// >>> rtl/brdic_pkg.sv
package brdic_pkg;
   // Register byte addresses
   localparam logic [7:0] CTRL_OFFS   = 8'h00;
   localparam logic [7:0] STATUS_OFFS = 8'h04;
   // Control field positions
   localparam int REQ_IGNORE_BIT  = 11;
   localparam int PRIO_HI_BIT     = 10;
   localparam int PRIO_LO_BIT     = 9;
   localparam int IDLE_CNT_LSB    = 6;
   localparam int IDLE_METHOD_BIT = 5;
   localparam int FIXED_ONE_BIT   = 4;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0010;
   localparam logic [31:0] CTRL_WMASK = 32'h0000_0fe0;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Burst priority encodings
   localparam logic [1:0] PRIO_ALL   = 2'h0;
   localparam logic [1:0] PRIO_REFR  = 2'h1;
   localparam logic [1:0] PRIO_NONE  = 2'h2;
   typedef enum logic [2:0] {
      BRDIC_IDLE = 3'h1,
      BRDIC_DMA_ACKNOWLEDGE_SELECT = 3'h2,
      BRDIC_WAIT = 3'h4
   } brdic_state_t;
endpackage

// >>> rtl/brdic_top.sv
// Design decisions made here: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
// Behaviour
// - Ignore control 0: external bus request is honoured and granted.
// - Ignore control 1: external bus request is never granted.
// - Priority 00: refresh and mastership granted during a DMA burst.
// - Priority 01: refresh granted, mastership held off during a burst.
// - Priority 10: neither refresh nor mastership granted during a burst.
// - Insert programmed idle cycles after acknowledged single-address access.
// - Idle code 0..7 means 0,1,2,4,6,8,10,12 idle cycles.
// - Idle insertion follows the insertion-method control.
// - Method 0: idle only when another device drives the data bus next.
// - Method 1: idle after every acknowledged access that ends while no idle count is running.
module brdic_top
   import brdic_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        external_bus_request,
   output logic             bus_grant_r,
   input  wire logic        refresh_request,
   output logic             refresh_grant_r,
   input  wire logic        dma_burst_active,
   input  wire logic        dma_single_access_end,
   input  wire logic        dma_acknowledge_select,
   input  wire logic        data_bus_other_next,
   output logic             dma_idle_active
);
   logic [31:0]  ctrl_r;
   logic         aw_held_r;
   logic         w_held_r;
   logic [7:0]   awaddr_r;
   logic [31:0]  wdata_r;
   logic [3:0]   wstrb_r;
   logic [1:0]   external_bus_request_sync_r;
   logic         req_ignore;
   logic [1:0]   prio;
   logic [2:0]   idle_code;
   logic         idle_method;
   logic         mast_allowed;
   logic         refr_allowed;
   logic         do_write;
   logic         ack_end;
   logic [3:0]   idle_cnt_r;
   brdic_state_t state_r;

   function automatic logic [3:0] idle_cycles(input logic [2:0] code);
      idle_cycles = (code == 3'h0) ? 4'h0 :
                    (code == 3'h1) ? 4'h1 : {code - 3'h1, 1'b0};
   endfunction

   assign req_ignore  = ctrl_r[REQ_IGNORE_BIT];
   assign prio        = ctrl_r[PRIO_HI_BIT:PRIO_LO_BIT];
   assign idle_code   = ctrl_r[IDLE_CNT_LSB +: 3];
   assign idle_method = ctrl_r[IDLE_METHOD_BIT];

   // Write channel capture, either order
   assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
   assign s_axi_wready  = !w_held_r && !s_axi_bvalid;
   assign do_write      = aw_held_r && w_held_r;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held_r <= 1'b0;
         w_held_r  <= 1'b0;
         awaddr_r  <= 8'h00;
         wdata_r   <= 32'h0000_0000;
         wstrb_r   <= 4'h0;
      end
      else if (do_write)
      begin
         aw_held_r <= 1'b0;
         w_held_r  <= 1'b0;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_held_r <= 1'b1;
            awaddr_r  <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_held_r <= 1'b1;
            wdata_r  <= s_axi_wdata;
            wstrb_r  <= s_axi_wstrb;
         end
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         ctrl_r <= CTRL_RESET;
      else if (do_write && awaddr_r[7:2] == CTRL_OFFS[7:2] && wstrb_r[1])
         ctrl_r[15:8] <= (wdata_r[15:8] & CTRL_WMASK[15:8])
                         | CTRL_RESET[15:8];
      else if (do_write && awaddr_r[7:2] == CTRL_OFFS[7:2] && wstrb_r[0])
         ctrl_r[7:0] <= (wdata_r[7:0] & CTRL_WMASK[7:0])
                        | CTRL_RESET[7:0];
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end
      else if (do_write)
      begin
         s_axi_bvalid <= 1'b1;
         if (awaddr_r[7:2] == CTRL_OFFS[7:2])
            s_axi_bresp <= RESP_OKAY;
         else
            s_axi_bresp <= RESP_SLVERR;
      end
      else if (s_axi_bready)
         s_axi_bvalid <= 1'b0;
   end

   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= RESP_OKAY;
         if (s_axi_araddr[7:2] == CTRL_OFFS[7:2])
            s_axi_rdata <= ctrl_r;
         else if (s_axi_araddr[7:2] == STATUS_OFFS[7:2])
            s_axi_rdata <= {27'h0, idle_cnt_r, bus_grant_r};
         else
         begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_SLVERR;
         end
      end
      else if (s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end

   // Bus request pin synchroniser
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         external_bus_request_sync_r <= 2'h0;
      else
         external_bus_request_sync_r <= {external_bus_request_sync_r[0], external_bus_request};
   end

   // Priority 11 treated as 10
   assign mast_allowed = !dma_burst_active || prio == PRIO_ALL;
   assign refr_allowed = !dma_burst_active || prio == PRIO_ALL
                         || prio == PRIO_REFR;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         bus_grant_r     <= 1'b0;
         refresh_grant_r <= 1'b0;
      end
      else
      begin
         bus_grant_r <= external_bus_request_sync_r[1] && !req_ignore
                        && mast_allowed;
         refresh_grant_r <= refresh_request && refr_allowed;
      end
   end

   // Idle insertion after acknowledged single-address access
   assign ack_end = dma_single_access_end && dma_acknowledge_select;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state_r    <= BRDIC_IDLE;
         idle_cnt_r <= 4'h0;
      end
      else
         case (state_r)
            BRDIC_IDLE:
               if (ack_end && idle_code != 3'h0)
               begin
                  if (idle_method)
                  begin
                     state_r    <= BRDIC_WAIT;
                     idle_cnt_r <= idle_cycles(idle_code);
                  end
                  else
                     state_r <= BRDIC_DMA_ACKNOWLEDGE_SELECT;
               end
            BRDIC_DMA_ACKNOWLEDGE_SELECT:
               if (data_bus_other_next)
               begin
                  state_r    <= BRDIC_WAIT;
                  idle_cnt_r <= idle_cycles(idle_code);
               end
            BRDIC_WAIT:
               if (idle_cnt_r == 4'h1)
               begin
                  state_r    <= BRDIC_IDLE;
                  idle_cnt_r <= 4'h0;
               end
               else
                  idle_cnt_r <= idle_cnt_r - 4'h1;
            default:
               state_r <= BRDIC_IDLE;
         endcase
   end

   assign dma_idle_active = (state_r == BRDIC_WAIT);

   a_grant_ignore: assert property (
      @(posedge aclk) disable iff (!aresetn)
      req_ignore |=> !bus_grant_r)
      else $error("grant while request ignored");
   a_grant_honour: assert property (
      @(posedge aclk) disable iff (!aresetn)
      external_bus_request_sync_r[1] && !req_ignore && !dma_burst_active |=> bus_grant_r)
      else $error("request not granted");
   a_prio_none: assert property (
      @(posedge aclk) disable iff (!aresetn)
      dma_burst_active && prio == PRIO_NONE
      |=> !refresh_grant_r && !bus_grant_r)
      else $error("grant during protected burst");
   a_prio_refr: assert property (
      @(posedge aclk) disable iff (!aresetn)
      dma_burst_active && prio == PRIO_REFR && refresh_request
      |=> refresh_grant_r && !bus_grant_r)
      else $error("priority 01 wrong");
   a_prio_all: assert property (
      @(posedge aclk) disable iff (!aresetn)
      dma_burst_active && prio == PRIO_ALL && refresh_request
      |=> refresh_grant_r)
      else $error("priority 00 refresh lost");
   sequence s_idle_start;
      state_r == BRDIC_IDLE && ack_end && idle_method && idle_code == 3'h7;
   endsequence
   a_idle_twelve: assert property (
      @(posedge aclk) disable iff (!aresetn)
      s_idle_start |=> dma_idle_active [*8] ##1 dma_idle_active [*4]
      ##1 !dma_idle_active)
      else $error("idle count 12 wrong");
   a_idle_hold: assert property (
      @(posedge aclk) disable iff (!aresetn)
      state_r == BRDIC_DMA_ACKNOWLEDGE_SELECT && !data_bus_other_next |=> !dma_idle_active)
      else $error("idle without other driver");
   a_idle_zero: assert property (
      @(posedge aclk) disable iff (!aresetn)
      state_r == BRDIC_IDLE && idle_code == 3'h0 |=> !dma_idle_active)
      else $error("idle with code zero");
   a_ctrl_reset: assert property (@(posedge aclk)
      !aresetn |=> ctrl_r == CTRL_RESET)
      else $error("control reset wrong");
endmodule

// >>> verif/brdic_far.sv
`timescale 1ns/1ps
module brdic_far
(
   input  wire logic aclk,
   output logic      external_bus_request,
   output logic      dma_single_access_end,
   output logic      dma_acknowledge_select,
   output logic      data_bus_other_next
);
   initial
   begin
      external_bus_request = 1'b0;
      dma_single_access_end = 1'b0;
      dma_acknowledge_select = 1'b0;
      data_bus_other_next = 1'b0;
   end
   task automatic ask(input logic on);
      @(posedge aclk);
      external_bus_request <= on;
   endtask
   // One access ends, to the acknowledged device or not
   task automatic access(input logic ack);
      @(posedge aclk);
      dma_single_access_end <= 1'b1;
      dma_acknowledge_select <= ack;
      @(posedge aclk);
      dma_single_access_end <= 1'b0;
      dma_acknowledge_select <= 1'b0;
   endtask
   task automatic handoff();
      @(posedge aclk);
      data_bus_other_next <= 1'b1;
      @(posedge aclk);
      data_bus_other_next <= 1'b0;
   endtask
endmodule

// >>> verif/tb.sv
`timescale 1ns/1ps
`define CHK(n, e, a) begin total_checks++; if ((a) !== (e)) begin \
   fail_count++; $display("MISMATCH %s exp %h got %h", n, e, a); end end
module tb;
   import brdic_pkg::*;
   logic        aclk, aresetn, awvalid, awready, wvalid, wready;
   logic        bvalid, bready, arvalid, arready, rvalid, rready;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, rd;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, resp;
   logic        ext_req, grant, refr, refr_gnt, burst;
   logic        acc_end, ack_sel, other, idle, eb;
   int          fail_count, total_checks, k;
   int          idl[8] = '{0, 1, 2, 4, 6, 8, 10, 12};
   brdic_top dut_u (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .external_bus_request(ext_req), .bus_grant_r(grant),
      .refresh_request(refr), .refresh_grant_r(refr_gnt),
      .dma_burst_active(burst), .dma_single_access_end(acc_end),
      .dma_acknowledge_select(ack_sel), .data_bus_other_next(other),
      .dma_idle_active(idle));
   brdic_far far_u (.aclk(aclk), .external_bus_request(ext_req),
      .dma_single_access_end(acc_end), .dma_acknowledge_select(ack_sel),
      .data_bus_other_next(other));
   always #12.5 aclk = ~aclk;
   task automatic close_out();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic hang();
      fail_count++;
      $display("MISMATCH handshake exp 1 got 0");
      close_out();
   endtask
   task automatic axw(input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s);
      awaddr  <= a;
      wdata   <= d;
      wstrb   <= s;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      for (int n = 0; n < 40; n++)
      begin
         @(posedge aclk);
         if (bvalid)
         begin
            resp = bresp;
            bready <= 1'b0;
            @(posedge aclk);
            return;
         end
         if (awready)
            awvalid <= 1'b0;
         if (wready)
            wvalid <= 1'b0;
      end
      hang();
   endtask
   task automatic axr(input logic [7:0] a);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      for (int n = 0; n < 40; n++)
      begin
         @(posedge aclk);
         if (rvalid)
         begin
            rd = rdata;
            resp = rresp;
            rready <= 1'b0;
            @(posedge aclk);
            return;
         end
         if (arready)
            arvalid <= 1'b0;
      end
      hang();
   endtask
   // One byte lane per write, high byte first
   task automatic wctl(input logic [31:0] v);
      axw(CTRL_OFFS, v, 4'h2);
      axw(CTRL_OFFS, v, 4'h1);
      `CHK("bresp", RESP_OKAY, resp)
   endtask
   function automatic logic [31:0] cv(input logic ig, input logic [1:0] p,
                                      input logic [2:0] c, input logic m);
      return (32'(ig) << REQ_IGNORE_BIT) | (32'(p) << PRIO_LO_BIT)
           | (32'(c) << IDLE_CNT_LSB) | (32'(m) << IDLE_METHOD_BIT);
   endfunction
   task automatic cnt(input int w);
      k = 0;
      repeat (w)
      begin
         @(posedge aclk);
         k += int'(idle === 1'b1);
      end
   endtask
   initial
   begin
      aclk = 1'b0;
      aresetn = 1'b0;
      awvalid = 1'b0;
      wvalid = 1'b0;
      bready = 1'b0;
      arvalid = 1'b0;
      rready = 1'b0;
      awaddr = 8'h00;
      araddr = 8'h00;
      wdata = 32'h0000_0000;
      wstrb = 4'h0;
      refr = 1'b0;
      burst = 1'b0;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      axr(CTRL_OFFS);
      `CHK("ctrl reset", CTRL_RESET, rd)
      axr(8'h08);
      `CHK("unmapped rresp", RESP_SLVERR, resp)
      axw(8'h08, 32'h0, 4'h1);
      `CHK("unmapped bresp", RESP_SLVERR, resp)
      // All fields set, priority at 10 since 11 is never written
      wctl(cv(1'b1, PRIO_NONE, 3'h7, 1'b1));
      axr(CTRL_OFFS);
      `CHK("ctrl all set", 32'h0000_0df0, rd)
      $display("test regs done");
      for (int ig = 0; ig < 2; ig++)
      begin
         wctl(cv(ig[0], 2'h0, 3'h0, 1'b0));
         far_u.ask(1'b1);
         repeat (6) @(posedge aclk);
         `CHK("grant", ~ig[0], grant)
         axr(STATUS_OFFS);
         `CHK("status grant", {31'h0, ~ig[0]}, rd)
         far_u.ask(1'b0);
         repeat (6) @(posedge aclk);
      end
      $display("test request ignore done");
      // Reserved priority code is never written
      for (int p = 0; p < 3; p++)
         for (int q = 0; q < 2; q++)
         begin
            wctl(cv(1'b0, p[1:0], 3'h0, 1'b0));
            burst <= 1'b1;
            refr <= (q == 0);
            far_u.ask(q == 1);
            repeat (6) @(posedge aclk);
            eb = q ? p == 0 : p != 2;
            `CHK("in burst", eb, q ? grant : refr_gnt)
            burst <= 1'b0;
            repeat (6) @(posedge aclk);
            `CHK("after burst", 1'b1, (q ? grant : refr_gnt))
            refr <= 1'b0;
            far_u.ask(1'b0);
            repeat (6) @(posedge aclk);
         end
      $display("test burst priority done");
      for (int c = 0; c < 8; c++)
      begin
         wctl(cv(1'b0, 2'h0, c[2:0], 1'b1));
         far_u.access(1'b1);
         cnt(16);
         `CHK("idle every access", idl[c], k)
      end
      wctl(cv(1'b0, 2'h0, 3'h3, 1'b0));
      far_u.access(1'b1);
      cnt(8);
      `CHK("idle before handoff", 0, k)
      far_u.handoff();
      cnt(16);
      `CHK("idle after handoff", 4, k)
      far_u.access(1'b0);
      far_u.handoff();
      cnt(16);
      `CHK("idle without ack", 0, k)
      $display("test idle insertion done");
      close_out();
   end
endmodule
